// >>> irig_pkg.sv
// constants, register map and types of the time code receiver
// assumes a 20 MHz clock and a 16-bit byte address on the register bus
package irig_pkg;
   // clock and tick divider
   localparam int CLK_NS   = 50;
   localparam int TICK_NS  = 100000;
   localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
   // symbol high-time windows in microseconds, converted to ticks
   localparam int ZERO_MIN_US = 1000;
   localparam int ZERO_MAX_US = 3000;
   localparam int ONE_MIN_US  = 4000;
   localparam int ONE_MAX_US  = 6000;
   localparam int MARK_MIN_US = 7000;
   localparam int MARK_MAX_US = 9000;
   localparam logic [6:0] ZERO_MIN = 7'((ZERO_MIN_US * 1000) / TICK_NS);
   localparam logic [6:0] ZERO_MAX = 7'((ZERO_MAX_US * 1000) / TICK_NS);
   localparam logic [6:0] ONE_MIN  = 7'((ONE_MIN_US * 1000) / TICK_NS);
   localparam logic [6:0] ONE_MAX  = 7'((ONE_MAX_US * 1000) / TICK_NS);
   localparam logic [6:0] MARK_MIN = 7'((MARK_MIN_US * 1000) / TICK_NS);
   localparam logic [6:0] MARK_MAX = 7'((MARK_MAX_US * 1000) / TICK_NS);
   // frame layout
   localparam logic [6:0] LAST_POS = 7'h63;
   localparam logic [3:0] MARK_UNIT = 4'h9;
   localparam int SEC_U = 1;
   localparam int SEC_T = 6;
   localparam int MIN_U = 10;
   localparam int MIN_T = 15;
   localparam int HR_U  = 20;
   localparam int HR_T  = 25;
   localparam int DAY_U = 30;
   localparam int DAY_T = 35;
   localparam int DAY_H = 40;
   localparam int YR_U  = 50;
   localparam int YR_T  = 55;
   // register byte addresses
   localparam logic [15:0] ENABLE_OFS = 16'h6000;
   localparam logic [15:0] CTRL_OFS   = 16'h6004;
   localparam logic [15:0] PEAK_OFS   = 16'h6008;
   localparam logic [15:0] ERR_OFS    = 16'h600c;
   localparam logic [15:0] SEC_OFS    = 16'h6020;
   localparam logic [15:0] MIN_OFS    = 16'h6024;
   localparam logic [15:0] HR_OFS     = 16'h6028;
   localparam logic [15:0] DAY_OFS    = 16'h602c;
   localparam logic [15:0] YR_OFS     = 16'h6030;
   localparam logic [15:0] IRQ_STS_OFS = 16'h6040;
   localparam logic [15:0] IRQ_MSK_OFS = 16'h6044;
   // field positions and reset values
   localparam int CTRL_AM_BIT = 0;
   localparam int EV_FRAME = 2;
   localparam int EV_SYNC  = 1;
   localparam int EV_FERR  = 0;
   localparam logic [7:0] CNT_MAX = 8'hff;
   localparam logic [2:0] MSK_RST = 3'h0;
   typedef enum logic [1:0] {SYM_ZERO, SYM_ONE, SYM_MARK, SYM_BAD} sym_e;
   typedef enum logic [1:0] {ST_HUNT, ST_REF, ST_DATA} st_e;
endpackage

// >>> sym_if.sv
// carries one classified symbol from the classifier to the frame decoder
// assumes both ends share one clock
`timescale 1ns/10ps
interface sym_if;
   logic             valid;
   irig_pkg::sym_e   kind;
   modport src (output valid, output kind);
   modport dst (input valid, input kind);
endinterface

// >>> symbol_classifier.sv
// measures the high time of each line pulse and classifies it
// assumes a line level synchronous to clk and a clear from the enable logic
`timescale 1ns/10ps
module symbol_classifier #(
   parameter int TICK_CYC = irig_pkg::TICK_CYC
) (
   input  wire logic clk,    // system clock
   input  wire logic rstn,   // async reset, active low
   input  wire logic clr,    // return to reset state
   input  wire logic line,   // selected time code level
   sym_if.src        sym     // classified symbol out
);
   localparam int DW = $clog2(TICK_CYC);
   logic [DW-1:0] div_q;
   logic          tick;
   logic          line_q;
   logic [6:0]    wid_q;
   irig_pkg::sym_e kind_d;

   // tick divider, one pulse per tick period
   assign tick = (div_q == DW'(TICK_CYC - 1));
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         div_q <= '0;
      else if (clr || tick)
         div_q <= '0;
      else
         div_q <= div_q + 1'b1;
   end

   // high-time measure, saturating
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         line_q <= 1'b0;
         wid_q  <= '0;
      end
      else if (clr)
      begin
         line_q <= 1'b0;
         wid_q  <= '0;
      end
      else
      begin
         line_q <= line;
         if (line && !line_q)
            wid_q <= '0;
         else if (line && tick && wid_q != 7'h7f)
            wid_q <= wid_q + 1'b1;
      end
   end

   // width windows to symbol kind
   always_comb
   begin
      if (wid_q >= irig_pkg::ZERO_MIN && wid_q <= irig_pkg::ZERO_MAX)
         kind_d = irig_pkg::SYM_ZERO;
      else if (wid_q >= irig_pkg::ONE_MIN && wid_q <= irig_pkg::ONE_MAX)
         kind_d = irig_pkg::SYM_ONE;
      else if (wid_q >= irig_pkg::MARK_MIN && wid_q <= irig_pkg::MARK_MAX)
         kind_d = irig_pkg::SYM_MARK;
      else
         kind_d = irig_pkg::SYM_BAD;
   end

   // symbol issued on the falling edge
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sym.valid <= 1'b0;
         sym.kind  <= irig_pkg::SYM_BAD;
      end
      else
      begin
         sym.valid <= !clr && !line && line_q;
         sym.kind  <= kind_d;
      end
   end
endmodule

// >>> irig_time_code_input.sv
// time code receiver: frame decoder, counters, peak level and apb registers
// assumes pins synchronous to clk; am_env is the demodulated am envelope
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
module irig_time_code_input (
   input  wire logic        clk,       // system clock, 20 MHz
   input  wire logic        rstn,      // async reset, active low
   input  wire logic        psel,      // apb select
   input  wire logic        penable,   // apb access phase
   input  wire logic        pwrite,    // apb write
   input  wire logic [15:0] paddr,     // apb byte address
   input  wire logic [31:0] pwdata,    // apb write data
   output logic      [31:0] prdata,    // apb read data
   output logic             pready,    // apb ready
   output logic             pslverr,   // apb error, unmapped
   input  wire logic        dcls_in,   // dc level shift code
   input  wire logic        am_env,    // am envelope level
   input  wire logic [15:0] am_sample, // am waveform sample
   output logic             irq        // level interrupt
);
   logic        en_q, en_prev_q, en_chg;
   logic [2:0]  ctl_q;
   logic [2:0]  msk_q, sts_q;
   logic [31:0] prdata_q, rdat;
   logic        pready_q, pslverr_q, irq_q, hit, acc, wr;
   logic        line, am_sel;
   irig_pkg::st_e st_q;
   logic [6:0]  pos_q;
   logic [3:0]  unit_q;
   logic [99:0] frame_q;
   logic        ev_good, ev_sync, ev_ferr;
   logic [3:0]  inc;
   logic [7:0]  cnt_q [4];
   logic [15:0] peak_q;
   logic [5:0]  sec_q, min_q;
   logic [4:0]  hr_q;
   logic [8:0]  day_q;
   logic [6:0]  yr_q;
   sym_if       sb ();

   function automatic logic [9:0] to_bin(input logic [3:0] h, input logic [3:0] t,
                                          input logic [3:0] u);
      to_bin = 10'(h) * 10'h064 + 10'(t) * 10'h00a + 10'(u);
   endfunction

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign irq     = irq_q;

   // enable and its change detector
   assign en_chg = en_q ^ en_prev_q;
   assign am_sel = ctl_q[irig_pkg::CTRL_AM_BIT];
   assign line   = en_q && (am_sel ? am_env : dcls_in);
   assign acc    = psel && penable;
   assign wr     = acc && pready_q && pwrite;

   symbol_classifier #(.TICK_CYC(irig_pkg::TICK_CYC)) u_cls (
      .clk  (clk),
      .rstn (rstn),
      .clr  (en_chg),
      .line (line),
      .sym  (sb.src)
   );

   // software enable and input control
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         en_q      <= 1'b0;
         en_prev_q <= 1'b0;
         ctl_q     <= '0;
      end
      else
      begin
         en_prev_q <= en_q;
         if (wr && paddr == irig_pkg::ENABLE_OFS)
            en_q <= pwdata[0];
         if (en_chg)
            ctl_q <= '0;
         else if (wr && paddr == irig_pkg::CTRL_OFS)
            ctl_q <= pwdata[2:0];
      end
   end

   // decoder events
   assign ev_ferr = sb.valid && sb.kind == irig_pkg::SYM_BAD;
   assign ev_sync = sb.valid && st_q == irig_pkg::ST_DATA && !ev_ferr &&
                    ((sb.kind == irig_pkg::SYM_MARK) != (unit_q == irig_pkg::MARK_UNIT));
   assign ev_good = sb.valid && st_q == irig_pkg::ST_DATA &&
                    sb.kind == irig_pkg::SYM_MARK && pos_q == irig_pkg::LAST_POS;

   // frame state: hunt for two markers, then walk positions
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_q   <= irig_pkg::ST_HUNT;
         pos_q  <= '0;
         unit_q <= '0;
      end
      else if (en_chg)
      begin
         st_q   <= irig_pkg::ST_HUNT;
         pos_q  <= '0;
         unit_q <= '0;
      end
      else if (sb.valid)
      begin
         case (st_q)
            irig_pkg::ST_HUNT:
               if (sb.kind == irig_pkg::SYM_MARK)
                  st_q <= irig_pkg::ST_REF;
            irig_pkg::ST_REF:
               if (sb.kind == irig_pkg::SYM_MARK)
               begin
                  st_q   <= irig_pkg::ST_DATA;
                  pos_q  <= 7'h01;
                  unit_q <= 4'h1;
               end
               else
                  st_q <= irig_pkg::ST_HUNT;
            default:
               if (ev_ferr || ev_sync)
                  st_q <= irig_pkg::ST_HUNT;
               else if (ev_good)
                  st_q <= irig_pkg::ST_REF;
               else
               begin
                  pos_q  <= pos_q + 1'b1;
                  unit_q <= (unit_q == irig_pkg::MARK_UNIT) ? 4'h0 : unit_q + 1'b1;
               end
         endcase
      end
   end

   // received bits by position
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         frame_q <= '0;
      else if (sb.valid && st_q == irig_pkg::ST_DATA)
         frame_q[pos_q] <= (sb.kind == irig_pkg::SYM_ONE);
   end

   // decoded fields, all taken together from one complete frame
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sec_q <= '0;
         min_q <= '0;
         hr_q  <= '0;
         day_q <= '0;
         yr_q  <= '0;
      end
      else if (ev_good)
      begin
         sec_q <= 6'(to_bin(4'h0, {1'b0, frame_q[irig_pkg::SEC_T +: 3]},
                            frame_q[irig_pkg::SEC_U +: 4]));
         min_q <= 6'(to_bin(4'h0, {1'b0, frame_q[irig_pkg::MIN_T +: 3]},
                            frame_q[irig_pkg::MIN_U +: 4]));
         hr_q  <= 5'(to_bin(4'h0, {2'b00, frame_q[irig_pkg::HR_T +: 2]},
                            frame_q[irig_pkg::HR_U +: 4]));
         day_q <= 9'(to_bin({2'b00, frame_q[irig_pkg::DAY_H +: 2]},
                            frame_q[irig_pkg::DAY_T +: 4],
                            frame_q[irig_pkg::DAY_U +: 4]));
         yr_q  <= 7'(to_bin(4'h0, frame_q[irig_pkg::YR_T +: 4],
                            frame_q[irig_pkg::YR_U +: 4]));
      end
   end

   // error and health counters: pps, am frame, dcls frame, sync
   assign inc = {ev_good, ev_ferr && am_sel, ev_ferr && !am_sel, ev_sync};
   for (genvar i = 0; i < 4; i++)
   begin : g_cnt
      always_ff @(posedge clk or negedge rstn)
      begin
         if (!rstn)
            cnt_q[i] <= '0;
         else if (en_chg)
            cnt_q[i] <= '0;
         else if (inc[i] && cnt_q[i] != irig_pkg::CNT_MAX)
            cnt_q[i] <= cnt_q[i] + 1'b1;
      end
   end

   // am peak tracker
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         peak_q <= '0;
      else if (en_chg)
         peak_q <= '0;
      else if (en_q && am_sel && am_sample > peak_q)
         peak_q <= am_sample;
   end

   // sticky status, set wins over write-one clear, masked onto irq
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sts_q <= '0;
         msk_q <= irig_pkg::MSK_RST;
         irq_q <= 1'b0;
      end
      else
      begin
         sts_q <= (sts_q & ~((wr && paddr == irig_pkg::IRQ_STS_OFS) ? pwdata[2:0] : 3'h0))
                  | {ev_good, ev_sync, ev_ferr};
         if (wr && paddr == irig_pkg::IRQ_MSK_OFS)
            msk_q <= pwdata[2:0];
         irq_q <= |(sts_q & msk_q);
      end
   end

   // read decode
   always_comb
   begin
      hit  = 1'b1;
      rdat = '0;
      if (paddr == irig_pkg::ENABLE_OFS)
         rdat = {31'h0, en_q};
      else if (paddr == irig_pkg::CTRL_OFS)
         rdat = {29'h0, ctl_q};
      else if (paddr == irig_pkg::PEAK_OFS)
         rdat = {16'h0, peak_q};
      else if (paddr == irig_pkg::ERR_OFS)
         rdat = {cnt_q[3], cnt_q[2], cnt_q[1], cnt_q[0]};
      else if (paddr == irig_pkg::SEC_OFS)
         rdat = {26'h0, sec_q};
      else if (paddr == irig_pkg::MIN_OFS)
         rdat = {26'h0, min_q};
      else if (paddr == irig_pkg::HR_OFS)
         rdat = {27'h0, hr_q};
      else if (paddr == irig_pkg::DAY_OFS)
         rdat = {23'h0, day_q};
      else if (paddr == irig_pkg::YR_OFS)
         rdat = {25'h0, yr_q};
      else if (paddr == irig_pkg::IRQ_STS_OFS)
         rdat = {29'h0, sts_q};
      else if (paddr == irig_pkg::IRQ_MSK_OFS)
         rdat = {29'h0, msk_q};
      else
         hit = 1'b0;
   end

   // apb slave: ready one cycle into the access phase
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
      end
      else
      begin
         pready_q  <= acc && !pready_q;
         pslverr_q <= acc && !pready_q && !hit;
         prdata_q  <= (acc && !pready_q && !pwrite) ? rdat : 32'h0;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   idle_no_symbol_a: assert property (!en_q && !$past(en_q) |-> !sb.valid)
      else $error("symbol seen while input disabled");
   toggle_resets_a: assert property (en_chg |=> ctl_q == 3'h0
                                     && st_q == irig_pkg::ST_HUNT)
      else $error("enable change did not reset interface");
   enable_clears_a: assert property (en_chg |=> cnt_q[0] == 8'h0 && cnt_q[3] == 8'h0
                                     && cnt_q[1] == 8'h0 && cnt_q[2] == 8'h0)
      else $error("counters not cleared on enable change");
   pps_count_a: assert property (ev_good && !en_chg && cnt_q[3] != 8'hff
                                 |=> cnt_q[3] == $past(cnt_q[3]) + 8'h01)
      else $error("pps count did not advance");
   am_ferr_a: assert property (ev_ferr && am_sel && !en_chg && cnt_q[2] != 8'hff
                               |=> cnt_q[2] == $past(cnt_q[2]) + 8'h01)
      else $error("am frame error not counted");
   dcls_ferr_a: assert property (ev_ferr && !am_sel && !en_chg && cnt_q[1] != 8'hff
                                 |=> cnt_q[1] == $past(cnt_q[1]) + 8'h01)
      else $error("dcls frame error not counted");
   sync_count_a: assert property (ev_sync && !en_chg && cnt_q[0] != 8'hff
                                  |=> cnt_q[0] == $past(cnt_q[0]) + 8'h01)
      else $error("sync error not counted");
   peak_hold_a: assert property (!en_chg && !$past(en_chg) |-> peak_q >= $past(peak_q))
      else $error("peak level fell without re-enable");
   fields_stable_a: assert property (!ev_good |=> $stable(min_q) && $stable(yr_q)
                                     && $stable(day_q) && $stable(sec_q) && $stable(hr_q))
      else $error("time fields changed outside a frame");
   cnt_saturate_a: assert property (cnt_q[0] == 8'hff && !en_chg
                                    |=> cnt_q[0] == 8'hff)
      else $error("sync counter wrapped");
   frame_seen_c: cover property (ev_good);
   sync_err_c:   cover property (ev_sync ##[1:300] ev_good);
   irq_raise_c:  cover property (!irq_q ##1 irq_q);
endmodule

// >>> irig_source_model.sv
// time code source model: drives the dcls and am lines and the am samples
// assumes the bench calls its tasks from a single process
`timescale 1ns/10ps
module irig_source_model (
   input  wire logic        clk,       // system clock
   output logic             dcls_in,   // dc level shift line
   output logic             am_env,    // am envelope line
   output logic      [15:0] am_sample  // am waveform sample
);
   // lines rest low between pulses
   initial
   begin
      dcls_in = 1'b0;
      am_env = 1'b0;
      am_sample = 16'h0000;
   end

   // one high pulse of n clocks on the chosen line, then a low gap
   task automatic pulse(input logic use_am, input int n);
      @(posedge clk);
      if (use_am)
         am_env <= 1'b1;
      else
         dcls_in <= 1'b1;
      repeat (n) @(posedge clk);
      am_env <= 1'b0;
      dcls_in <= 1'b0;
      repeat (12) @(posedge clk);
   endtask

   // hold one sample for a few clocks, then fall back to zero
   task automatic sample(input logic [15:0] v);
      @(posedge clk);
      am_sample <= v;
      repeat (3) @(posedge clk);
      am_sample <= 16'h0000;
   endtask
endmodule

// >>> irig_time_code_input_bench.sv
// self-checking bench of the time code receiver
// assumes the source model and the package; apb master driven at rising edges
`timescale 1ns/10ps
module irig_time_code_input_bench;
   logic        clk, rstn, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        dcls_in, am_env;
   logic [15:0] am_sample, pk;
   logic [2:0]  c;
   int          bad_count, comparisons, n, m;

   irig_time_code_input dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dcls_in(dcls_in), .am_env(am_env), .am_sample(am_sample),
      .irq(irq));
   irig_source_model src (.clk(clk), .dcls_in(dcls_in), .am_env(am_env),
      .am_sample(am_sample));

   // clock
   always #25 clk = ~clk;

   // counter field saturating at its maximum
   function automatic logic [7:0] sat(input int k);
      return (k > 255) ? 8'hff : 8'(k);
   endfunction

   // expected error word: pps, am frame, dcls frame, sync
   function automatic logic [31:0] ew(input int p, input int a, input int d, input int s);
      return {sat(p), sat(a), sat(d), sat(s)};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one apb transfer; result in rd and err
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (k >= 20)
         bad_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic expect_reg(input logic [15:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask

   task automatic pulses(input logic am, input int k);
      repeat (k) src.pulse(am, 2 + int'($urandom % 10));
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // reset and idle bus
   initial
   begin
      clk = 1'b0;
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0000;
      pwdata = 32'h0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
   end

   // watchdog
   initial
   begin
      repeat (30000) @(posedge clk);
      bad_count++;
      conclude();
   end

   // main sequence
   initial
   begin
      void'($urandom(32'h7e53));
      @(posedge rstn);
      expect_reg(irig_pkg::PEAK_OFS, 32'h0);
      expect_reg(irig_pkg::ERR_OFS, 32'h0);
      expect_reg(irig_pkg::CTRL_OFS, 32'h0);
      apb(1'b0, 16'h6100, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      apb(1'b1, irig_pkg::ERR_OFS, 32'hffffffff);
      expect_reg(irig_pkg::ERR_OFS, 32'h0);
      apb(1'b1, irig_pkg::ENABLE_OFS, 32'h1);
      c = 3'($urandom) & 3'h6;
      apb(1'b1, irig_pkg::CTRL_OFS, {29'h0, c});
      expect_reg(irig_pkg::CTRL_OFS, {29'h0, c});
      n = 3 + int'($urandom % 5);
      repeat (n)
      begin
         pulses(1'b0, 1);
         pulses(1'b1, 1);
      end
      expect_reg(irig_pkg::ERR_OFS, ew(0, 0, n, 0));
      expect_reg(irig_pkg::IRQ_STS_OFS, 32'h1);
      // a set mask bit lets its status bit through to irq
      check({31'h0, irq}, 32'h0);
      apb(1'b1, irig_pkg::IRQ_MSK_OFS, 32'h1);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, irig_pkg::IRQ_MSK_OFS, 32'h0);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h0);
      apb(1'b1, irig_pkg::IRQ_MSK_OFS, 32'h1);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, irig_pkg::IRQ_STS_OFS, 32'h1);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h0);
      expect_reg(irig_pkg::IRQ_STS_OFS, 32'h0);
      apb(1'b1, irig_pkg::CTRL_OFS, {29'h0, c | 3'h1});
      m = 2 + int'($urandom % 5);
      repeat (m)
      begin
         pulses(1'b1, 1);
         pulses(1'b0, 1);
      end
      expect_reg(irig_pkg::ERR_OFS, ew(0, m, n, 0));
      pk = 16'h0;
      repeat (6)
      begin
         rd = $urandom;
         if (rd[15:0] > pk)
            pk = rd[15:0];
         src.sample(rd[15:0]);
      end
      repeat (4) @(posedge clk);
      expect_reg(irig_pkg::PEAK_OFS, {16'h0, pk});
      apb(1'b1, irig_pkg::CTRL_OFS, {29'h0, c});
      src.sample(16'hffff);
      repeat (4) @(posedge clk);
      expect_reg(irig_pkg::PEAK_OFS, {16'h0, pk});
      repeat (260) src.pulse(1'b0, 2);
      expect_reg(irig_pkg::ERR_OFS, ew(0, m, 260, 0));
      apb(1'b1, irig_pkg::ENABLE_OFS, 32'h0);
      expect_reg(irig_pkg::ERR_OFS, 32'h0);
      expect_reg(irig_pkg::PEAK_OFS, 32'h0);
      expect_reg(irig_pkg::CTRL_OFS, 32'h0);
      pulses(1'b0, 3);
      pulses(1'b1, 3);
      expect_reg(irig_pkg::ERR_OFS, 32'h0);
      apb(1'b1, irig_pkg::ENABLE_OFS, 32'h1);
      expect_reg(irig_pkg::ERR_OFS, 32'h0);
      pulses(1'b0, 1);
      expect_reg(irig_pkg::ERR_OFS, ew(0, 0, 1, 0));
      conclude();
   end
endmodule
